// file: rtl/plcm_channel.sv
// Loop mode sequencing and modulator routing for one PLL channel
//
// What this block does
// [R01] After reset the analog loop runs free from the crystal input.
// [R02] Three-loop: oscillator loop acquires only after its clock is detected.
// [R03] Oscillator phase error is filtered and drives the analog modulator.
// [R04] Three-loop: filtered reference correction offsets the oscillator modulator.
// [R05] Three-loop DCO steps the reference feedback modulator by the step.
// [R06] Software orders bandwidths: reference lowest, oscillator higher, analog highest.
// [R07] Three-loop reference loss enters holdover, acting like two-loop oscillator.
// [R08] Two-loop reference: reference filter drives the analog modulator directly.
// [R09] Two-loop reference DCO steps the reference feedback modulator by step.
// [R10] Software keeps reference bandwidth below reference/50 and below 4 kHz.
// [R11] Two-loop reference loss enters holdover, acting like one-loop mode.
// [R12] Two-loop oscillator: oscillator filter drives the analog modulator.
// [R13] Two-loop oscillator DCO steps the oscillator feedback modulator by the step.
// [R14] Software keeps oscillator bandwidth below oscillator/50 and below 4 kHz.
// [R15] Two-loop oscillator: lost oscillator clock falls back to one-loop.
// [R16] Each digital loop controls a 40-bit fractional modulator word.
// [R17] A mode field picks one of four loop modes and routing.
// [R18] A returning input restarts acquisition of the affected loop.
//
// The AXI4-Lite register port and the address map were decided locally.
`timescale 1ns/1ps
module plcm_channel #(
  parameter logic [plcm_pkg::WORD_W-1:0] NOM_ANALOG = 40'h00_0000_0000,
  parameter logic [plcm_pkg::WORD_W-1:0] NOM_OSC_FB = 40'h00_0000_0000,
  parameter logic [plcm_pkg::WORD_W-1:0] NOM_REF_FB = 40'h00_0000_0000,
  parameter int unsigned                 KP_SHIFT   = 8,
  parameter int unsigned                 KI_SHIFT   = 0
) (
  // Clock and reset
  input  wire logic                                aclk,
  input  wire logic                                aresetn,
  // AXI4-Lite write address and data
  input  wire logic [plcm_pkg::ADDR_W-1:0]         s_axi_awaddr,
  input  wire logic                                s_axi_awvalid,
  output logic                                     s_axi_awready,
  input  wire logic [plcm_pkg::DATA_W-1:0]         s_axi_wdata,
  input  wire logic [3:0]                          s_axi_wstrb,
  input  wire logic                                s_axi_wvalid,
  output logic                                     s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]                               s_axi_bresp,
  output logic                                     s_axi_bvalid,
  input  wire logic                                s_axi_bready,
  // AXI4-Lite read
  input  wire logic [plcm_pkg::ADDR_W-1:0]         s_axi_araddr,
  input  wire logic                                s_axi_arvalid,
  output logic                                     s_axi_arready,
  output logic [plcm_pkg::DATA_W-1:0]              s_axi_rdata,
  output logic [1:0]                               s_axi_rresp,
  output logic                                     s_axi_rvalid,
  input  wire logic                                s_axi_rready,
  // Clock detector pins, asynchronous
  input  wire logic                                osc_clk_detected,
  input  wire logic                                ref_valid_selected,
  // Phase detector words, same clock
  input  wire logic signed [plcm_pkg::ERR_W-1:0]   ref_phase_err,
  input  wire logic signed [plcm_pkg::ERR_W-1:0]   osc_phase_err,
  // Modulator control nodes
  output logic [plcm_pkg::WORD_W-1:0]              analog_sdm_word,
  output logic [plcm_pkg::WORD_W-1:0]              osc_fb_sdm_word,
  output logic [plcm_pkg::WORD_W-1:0]              ref_fb_sdm_word,
  // Channel status
  output logic                                     free_run,
  output logic                                     holdover,
  output logic                                     ref_loop_active,
  output logic                                     osc_loop_active
);

  localparam int unsigned DW = plcm_pkg::DATA_W;
  localparam int unsigned WW = plcm_pkg::WORD_W;
  localparam int unsigned AW = plcm_pkg::ADDR_W;

  function automatic logic addr_known(input logic [AW-1:0] a);
    if (a == plcm_pkg::ADDR_CTRL)           addr_known = 1'b1;
    else if (a == plcm_pkg::ADDR_STEP_LO)   addr_known = 1'b1;
    else if (a == plcm_pkg::ADDR_STEP_HI)   addr_known = 1'b1;
    else if (a == plcm_pkg::ADDR_DCO_CMD)   addr_known = 1'b1;
    else if (a == plcm_pkg::ADDR_STATUS)    addr_known = 1'b1;
    else if (a == plcm_pkg::ADDR_ANALOG_LO) addr_known = 1'b1;
    else if (a == plcm_pkg::ADDR_ANALOG_HI) addr_known = 1'b1;
    else                                    addr_known = 1'b0;
  endfunction : addr_known

  function automatic logic [DW-1:0] merge_strb(input logic [DW-1:0] old_v,
                                               input logic [DW-1:0] new_v,
                                               input logic [3:0]    strb);
    for (int i = 0; i < 4; i++)
      merge_strb[i*8 +: 8] = strb[i] ? new_v[i*8 +: 8] : old_v[i*8 +: 8];
  endfunction : merge_strb

  // Pin synchronisers
  logic [1:0] osc_sync_q;
  logic [1:0] ref_sync_q;
  logic       osc_det;
  logic       ref_val;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      osc_sync_q <= 2'h0;
      ref_sync_q <= 2'h0;
    end
    else
    begin
      osc_sync_q <= {osc_sync_q[0], osc_clk_detected};
      ref_sync_q <= {ref_sync_q[0], ref_valid_selected};
    end
  end

  assign osc_det = osc_sync_q[1];
  assign ref_val = ref_sync_q[1];

  // Bus slave and register state
  logic              awready_q, awready_d, wready_q, wready_d;
  logic              aw_full_q, aw_full_d, w_full_q, w_full_d;
  logic [AW-1:0]     awaddr_q, awaddr_d;
  logic [DW-1:0]     wdata_q, wdata_d;
  logic [3:0]        wstrb_q, wstrb_d;
  logic              bvalid_q, bvalid_d, rvalid_q, rvalid_d;
  logic              arready_q, arready_d;
  logic [1:0]        bresp_q, bresp_d, rresp_q, rresp_d;
  logic [DW-1:0]     rdata_q, rdata_d;
  logic [DW-1:0]     ctrl_q, ctrl_d, step_lo_q, step_lo_d;
  logic [plcm_pkg::STEP_HI_W-1:0] step_hi_q, step_hi_d;
  logic              do_write, step_up, step_down;
  logic [DW-1:0]     status_word;
  logic [DW-1:0]     cmd_word;

  always_comb
  begin
    awready_d = awready_q;
    wready_d  = wready_q;
    aw_full_d = aw_full_q;
    w_full_d  = w_full_q;
    awaddr_d  = awaddr_q;
    wdata_d   = wdata_q;
    wstrb_d   = wstrb_q;
    bvalid_d  = bvalid_q;
    bresp_d   = bresp_q;
    arready_d = arready_q;
    rvalid_d  = rvalid_q;
    rresp_d   = rresp_q;
    rdata_d   = rdata_q;
    ctrl_d    = ctrl_q;
    step_lo_d = step_lo_q;
    step_hi_d = step_hi_q;
    cmd_word  = '0;
    step_up   = 1'b0;
    step_down = 1'b0;
    if (s_axi_awvalid && awready_q)
    begin
      aw_full_d = 1'b1;
      awaddr_d  = s_axi_awaddr;
    end
    if (s_axi_wvalid && wready_q)
    begin
      w_full_d = 1'b1;
      wdata_d  = s_axi_wdata;
      wstrb_d  = s_axi_wstrb;
    end
    do_write = aw_full_q && w_full_q && !bvalid_q;
    if (do_write)
    begin
      aw_full_d = 1'b0;
      w_full_d  = 1'b0;
      bvalid_d  = 1'b1;
      bresp_d   = addr_known(awaddr_q) ? plcm_pkg::RESP_OKAY
                                       : plcm_pkg::RESP_SLVERR;
      if (awaddr_q == plcm_pkg::ADDR_CTRL)
        ctrl_d = merge_strb(ctrl_q, wdata_q, wstrb_q);
      else if (awaddr_q == plcm_pkg::ADDR_STEP_LO)
        step_lo_d = merge_strb(step_lo_q, wdata_q, wstrb_q);
      else if (awaddr_q == plcm_pkg::ADDR_STEP_HI)
      begin
        if (wstrb_q[0])
          step_hi_d = wdata_q[plcm_pkg::STEP_HI_W-1:0];
      end
      else if (awaddr_q == plcm_pkg::ADDR_DCO_CMD)
        cmd_word = merge_strb('0, wdata_q, wstrb_q);
      // Both directions at once cancel rather than pick a winner
      step_up   = cmd_word[plcm_pkg::DCO_UP_BIT] &&
                  !cmd_word[plcm_pkg::DCO_DOWN_BIT];
      step_down = cmd_word[plcm_pkg::DCO_DOWN_BIT] &&
                  !cmd_word[plcm_pkg::DCO_UP_BIT];
    end
    if (bvalid_q && s_axi_bready)
      bvalid_d = 1'b0;
    awready_d = !aw_full_d && !bvalid_d;
    wready_d  = !w_full_d && !bvalid_d;
    if (s_axi_arvalid && arready_q)
    begin
      rvalid_d = 1'b1;
      rresp_d  = addr_known(s_axi_araddr) ? plcm_pkg::RESP_OKAY
                                          : plcm_pkg::RESP_SLVERR;
      if (s_axi_araddr == plcm_pkg::ADDR_CTRL)
        rdata_d = ctrl_q;
      else if (s_axi_araddr == plcm_pkg::ADDR_STEP_LO)
        rdata_d = step_lo_q;
      else if (s_axi_araddr == plcm_pkg::ADDR_STEP_HI)
        rdata_d = {{(DW-plcm_pkg::STEP_HI_W){1'b0}}, step_hi_q};
      else if (s_axi_araddr == plcm_pkg::ADDR_STATUS)
        rdata_d = status_word;
      else if (s_axi_araddr == plcm_pkg::ADDR_ANALOG_LO)
        rdata_d = analog_sdm_word[DW-1:0];
      else if (s_axi_araddr == plcm_pkg::ADDR_ANALOG_HI)
        rdata_d = {{(2*DW-WW){1'b0}}, analog_sdm_word[WW-1:DW]};
      else
        rdata_d = '0;
    end
    else if (rvalid_q && s_axi_rready)
      rvalid_d = 1'b0;
    arready_d = !rvalid_d;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      awready_q <= 1'b0;
      wready_q  <= 1'b0;
      aw_full_q <= 1'b0;
      w_full_q  <= 1'b0;
      awaddr_q  <= '0;
      wdata_q   <= '0;
      wstrb_q   <= 4'h0;
      bvalid_q  <= 1'b0;
      bresp_q   <= plcm_pkg::RESP_OKAY;
      arready_q <= 1'b0;
      rvalid_q  <= 1'b0;
      rresp_q   <= plcm_pkg::RESP_OKAY;
      rdata_q   <= '0;
      ctrl_q    <= plcm_pkg::CTRL_RESET;
      step_lo_q <= plcm_pkg::STEP_LO_RESET;
      step_hi_q <= plcm_pkg::STEP_HI_RESET;
    end
    else
    begin
      awready_q <= awready_d;
      wready_q  <= wready_d;
      aw_full_q <= aw_full_d;
      w_full_q  <= w_full_d;
      awaddr_q  <= awaddr_d;
      wdata_q   <= wdata_d;
      wstrb_q   <= wstrb_d;
      bvalid_q  <= bvalid_d;
      bresp_q   <= bresp_d;
      arready_q <= arready_d;
      rvalid_q  <= rvalid_d;
      rresp_q   <= rresp_d;
      rdata_q   <= rdata_d;
      ctrl_q    <= ctrl_d;
      step_lo_q <= step_lo_d;
      step_hi_q <= step_hi_d;
    end
  end

  // Channel sequencing
  plcm_pkg::plcm_mode_t  mode;
  plcm_pkg::plcm_state_t state_q, state_d;
  logic                  ref_run, osc_run, ref_dco_en, osc_dco_en;

  assign mode = plcm_pkg::plcm_mode_t'(
                  ctrl_q[plcm_pkg::CTRL_MODE_LSB +: plcm_pkg::CTRL_MODE_W]);
  assign ref_dco_en = ctrl_q[plcm_pkg::CTRL_REF_DCO_BIT];
  assign osc_dco_en = ctrl_q[plcm_pkg::CTRL_OSC_DCO_BIT];

  always_comb
  begin
    state_d = state_q;
    case (mode)
      plcm_pkg::MODE_ONE_LOOP:
        state_d = plcm_pkg::ST_FREE_RUN;                        // [R01] [R17]
      plcm_pkg::MODE_TWO_OSC:
        state_d = osc_det ? plcm_pkg::ST_OSC_ACQ               // [R12] [R18]
                          : plcm_pkg::ST_FREE_RUN;              // [R15]
      plcm_pkg::MODE_TWO_REF:
        if (ref_val)
          state_d = plcm_pkg::ST_REF_ACQ;                       // [R08] [R18]
        else if (state_q == plcm_pkg::ST_REF_ACQ ||
                 state_q == plcm_pkg::ST_HOLDOVER)
          state_d = plcm_pkg::ST_HOLDOVER;                      // [R11]
        else
          state_d = plcm_pkg::ST_FREE_RUN;
      plcm_pkg::MODE_THREE:
        // Reference loop nests inside the oscillator loop, so it waits
        if (!osc_det)
          state_d = plcm_pkg::ST_FREE_RUN;                      // [R02]
        else if (ref_val)
          state_d = plcm_pkg::ST_REF_ACQ;                       // [R04] [R18]
        else if (state_q == plcm_pkg::ST_REF_ACQ ||
                 state_q == plcm_pkg::ST_HOLDOVER)
          state_d = plcm_pkg::ST_HOLDOVER;                      // [R07]
        else
          state_d = plcm_pkg::ST_OSC_ACQ;                       // [R02]
      default:
        state_d = plcm_pkg::ST_FREE_RUN;
    endcase
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      state_q <= plcm_pkg::ST_FREE_RUN;                         // [R01]
    else
      state_q <= state_d;
  end

  assign ref_run = (state_q == plcm_pkg::ST_REF_ACQ);
  assign osc_run = (mode == plcm_pkg::MODE_THREE &&
                    state_q != plcm_pkg::ST_FREE_RUN) ||
                   (mode == plcm_pkg::MODE_TWO_OSC &&
                    state_q == plcm_pkg::ST_OSC_ACQ);

  // Digital loop filters
  logic signed [WW-1:0] ref_corr, osc_corr;

  plcm_loop_filter #(
    .ERR_W    (plcm_pkg::ERR_W),
    .WORD_W   (WW),
    .KP_SHIFT (KP_SHIFT),
    .KI_SHIFT (KI_SHIFT)
  ) u_ref_filter (
    .aclk       (aclk),
    .aresetn    (aresetn),
    .run        (ref_run),
    .phase_err  (ref_phase_err),
    .correction (ref_corr)
  );

  plcm_loop_filter #(
    .ERR_W    (plcm_pkg::ERR_W),
    .WORD_W   (WW),
    .KP_SHIFT (KP_SHIFT),
    .KI_SHIFT (KI_SHIFT)
  ) u_osc_filter (
    .aclk       (aclk),
    .aresetn    (aresetn),
    .run        (osc_run),                                      // [R03]
    .phase_err  (osc_phase_err),
    .correction (osc_corr)
  );

  // DCO offset and modulator routing
  logic [WW-1:0] dco_acc_q, dco_acc_d, step_word;
  logic [WW-1:0] analog_q, analog_d, osc_fb_q, osc_fb_d, ref_fb_q, ref_fb_d;
  logic          dco_on_ref, dco_on_osc;
  logic          free_run_q, hold_q, ref_act_q, osc_act_q;

  assign step_word  = {step_hi_q, step_lo_q};
  assign dco_on_ref = ref_dco_en && (mode == plcm_pkg::MODE_THREE ||
                                     mode == plcm_pkg::MODE_TWO_REF);
  assign dco_on_osc = osc_dco_en && (mode == plcm_pkg::MODE_TWO_OSC);

  always_comb
  begin
    dco_acc_d = dco_acc_q;
    if (!dco_on_ref && !dco_on_osc)
      dco_acc_d = '0;
    else if (step_up)
      dco_acc_d = dco_acc_q + step_word;                 // [R05] [R09] [R13]
    else if (step_down)
      dco_acc_d = dco_acc_q - step_word;                 // [R05] [R09] [R13]
    analog_d = NOM_ANALOG;                                      // [R01] [R16]
    osc_fb_d = NOM_OSC_FB;
    ref_fb_d = NOM_REF_FB;
    if (osc_run)
      analog_d = NOM_ANALOG + osc_corr;                         // [R03] [R12]
    else if (mode == plcm_pkg::MODE_TWO_REF && ref_run)
      analog_d = NOM_ANALOG + ref_corr;                         // [R08]
    if (mode == plcm_pkg::MODE_THREE && ref_run)
      osc_fb_d = NOM_OSC_FB + ref_corr;                         // [R04]
    if (dco_on_osc)
      osc_fb_d = NOM_OSC_FB + dco_acc_q;                        // [R13]
    if (dco_on_ref)
      ref_fb_d = NOM_REF_FB + dco_acc_q;                        // [R05] [R09]
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      dco_acc_q  <= '0;
      analog_q   <= '0;
      osc_fb_q   <= '0;
      ref_fb_q   <= '0;
      free_run_q <= 1'b1;
      hold_q     <= 1'b0;
      ref_act_q  <= 1'b0;
      osc_act_q  <= 1'b0;
    end
    else
    begin
      dco_acc_q  <= dco_acc_d;
      analog_q   <= analog_d;
      osc_fb_q   <= osc_fb_d;
      ref_fb_q   <= ref_fb_d;
      free_run_q <= (state_q == plcm_pkg::ST_FREE_RUN);
      hold_q     <= (state_q == plcm_pkg::ST_HOLDOVER);
      ref_act_q  <= ref_run;
      osc_act_q  <= osc_run;
    end
  end

  always_comb
  begin
    status_word = '0;
    status_word[plcm_pkg::ST_STATE_LSB +: 2] = state_q;
    status_word[plcm_pkg::ST_OSC_DET_BIT]    = osc_det;
    status_word[plcm_pkg::ST_REF_VAL_BIT]    = ref_val;
    status_word[plcm_pkg::ST_REF_RUN_BIT]    = ref_act_q;
    status_word[plcm_pkg::ST_OSC_RUN_BIT]    = osc_act_q;
    status_word[plcm_pkg::ST_HOLD_BIT]       = hold_q;
  end

  assign s_axi_awready   = awready_q;
  assign s_axi_wready    = wready_q;
  assign s_axi_bvalid    = bvalid_q;
  assign s_axi_bresp     = bresp_q;
  assign s_axi_arready   = arready_q;
  assign s_axi_rvalid    = rvalid_q;
  assign s_axi_rresp     = rresp_q;
  assign s_axi_rdata     = rdata_q;
  assign analog_sdm_word = analog_q;
  assign osc_fb_sdm_word = osc_fb_q;
  assign ref_fb_sdm_word = ref_fb_q;
  assign free_run        = free_run_q;
  assign holdover        = hold_q;
  assign ref_loop_active = ref_act_q;
  assign osc_loop_active = osc_act_q;

endmodule : plcm_channel

// file: rtl/plcm_loop_filter.sv
// Proportional-integral digital loop filter for one digital loop
`timescale 1ns/1ps
module plcm_loop_filter #(
  parameter int unsigned ERR_W    = plcm_pkg::ERR_W,
  parameter int unsigned WORD_W   = plcm_pkg::WORD_W,
  parameter int unsigned KP_SHIFT = 8,
  parameter int unsigned KI_SHIFT = 0
) (
  // Clock and reset
  input  wire logic                     aclk,
  input  wire logic                     aresetn,
  // Loop control and phase detector word
  input  wire logic                     run,
  input  wire logic signed [ERR_W-1:0]  phase_err,
  // Filtered correction
  output logic signed [WORD_W-1:0]      correction
);

  logic signed [WORD_W-1:0] integ_q;
  logic signed [WORD_W-1:0] integ_d;
  logic signed [WORD_W-1:0] corr_q;
  logic signed [WORD_W-1:0] corr_d;
  logic signed [WORD_W-1:0] err_ext;

  // A stopped loop forgets its history so reacquisition starts clean
  always_comb
  begin
    err_ext = {{(WORD_W-ERR_W){phase_err[ERR_W-1]}}, phase_err};
    if (run)
    begin
      integ_d = integ_q + (err_ext <<< KI_SHIFT);
      corr_d  = integ_d + (err_ext <<< KP_SHIFT);
    end
    else
    begin
      integ_d = '0;
      corr_d  = '0;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      integ_q <= '0;
      corr_q  <= '0;
    end
    else
    begin
      integ_q <= integ_d;
      corr_q  <= corr_d;
    end
  end

  assign correction = corr_q;

endmodule : plcm_loop_filter

// file: rtl/plcm_pkg.sv
// Shared constants and types for the PLL channel loop mode control
package plcm_pkg;

  localparam int unsigned DATA_W    = 32;
  localparam int unsigned ADDR_W    = 8;
  localparam int unsigned WORD_W    = 40;
  localparam int unsigned ERR_W     = 24;
  localparam int unsigned STEP_HI_W = WORD_W - DATA_W;

  // Register byte addresses
  localparam logic [ADDR_W-1:0] ADDR_CTRL      = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_STEP_LO   = 8'h04;
  localparam logic [ADDR_W-1:0] ADDR_STEP_HI   = 8'h08;
  localparam logic [ADDR_W-1:0] ADDR_DCO_CMD   = 8'h0C;
  localparam logic [ADDR_W-1:0] ADDR_STATUS    = 8'h10;
  localparam logic [ADDR_W-1:0] ADDR_ANALOG_LO = 8'h14;
  localparam logic [ADDR_W-1:0] ADDR_ANALOG_HI = 8'h18;

  // Field positions
  localparam int unsigned CTRL_MODE_LSB    = 0;
  localparam int unsigned CTRL_MODE_W      = 2;
  localparam int unsigned CTRL_REF_DCO_BIT = 2;
  localparam int unsigned CTRL_OSC_DCO_BIT = 3;
  localparam int unsigned DCO_UP_BIT       = 0;
  localparam int unsigned DCO_DOWN_BIT     = 1;
  localparam int unsigned ST_STATE_LSB     = 0;
  localparam int unsigned ST_OSC_DET_BIT   = 2;
  localparam int unsigned ST_REF_VAL_BIT   = 3;
  localparam int unsigned ST_REF_RUN_BIT   = 4;
  localparam int unsigned ST_OSC_RUN_BIT   = 5;
  localparam int unsigned ST_HOLD_BIT      = 6;

  // Reset values
  localparam logic [DATA_W-1:0]    CTRL_RESET    = 32'h0000_0000;
  localparam logic [DATA_W-1:0]    STEP_LO_RESET = 32'h0000_0000;
  localparam logic [STEP_HI_W-1:0] STEP_HI_RESET = 8'h00;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    MODE_ONE_LOOP,
    MODE_TWO_REF,
    MODE_TWO_OSC,
    MODE_THREE
  } plcm_mode_t;

  typedef enum logic [1:0] {
    ST_FREE_RUN,
    ST_OSC_ACQ,
    ST_REF_ACQ,
    ST_HOLDOVER
  } plcm_state_t;

endpackage : plcm_pkg

// file: testbench/plcm_channel_properties.sv
// Port-level checks of loop sequencing for one PLL channel
`timescale 1ns/1ps
module plcm_channel_properties (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Detector pins and status
  input wire logic osc_clk_detected,
  input wire logic ref_valid_selected,
  input wire logic free_run,
  input wire logic holdover,
  input wire logic ref_loop_active,
  input wire logic osc_loop_active
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_reset_quiet: assert property (disable iff (1'b0)
    !aresetn |=> free_run && !holdover && !osc_loop_active
    && !ref_loop_active) else $error("status not reset");
  a_osc_needs_pin: assert property ($rose(osc_loop_active)
    |-> $past(osc_clk_detected, 3)) else $error("osc loop early");
  a_ref_needs_pin: assert property ($rose(ref_loop_active)
    |-> $past(ref_valid_selected, 3)) else $error("ref loop early");
  a_osc_loss_stop: assert property ($fell(osc_clk_detected)
    |-> ##[1:6] !osc_loop_active) else $error("osc loop kept");
  a_ref_loss_stop: assert property ($fell(ref_valid_selected)
    |-> ##[1:6] !ref_loop_active) else $error("ref loop kept");
  a_hold_excl: assert property (holdover
    |-> !free_run && !ref_loop_active) else $error("holdover overlap");
  a_free_idle: assert property (free_run |-> !holdover
    && !osc_loop_active && !ref_loop_active) else $error("free busy");
  a_ref_return: assert property ($rose(ref_valid_selected)
    && holdover |-> ##[1:6] ref_loop_active) else $error("no retry");
endmodule : plcm_channel_properties

bind plcm_channel plcm_channel_properties u_props (.aclk, .aresetn,
  .osc_clk_detected, .ref_valid_selected, .free_run, .holdover,
  .ref_loop_active, .osc_loop_active);

// file: testbench/plcm_channel_tb_top.sv
// Scenario bench for the PLL channel loop mode control
`timescale 1ns/1ps
module plcm_channel_tb_top;
  localparam logic [39:0] NA  = 40'h10_0000_0000;
  localparam logic [39:0] NO  = 40'h20_0000_0000;
  localparam logic [39:0] NR  = 40'hFF_FFFF_FFF8;
  localparam logic [39:0] STP = 40'h01_0000_0010;
  logic               aclk, osc_on = '0, ref_on = '0, aresetn = '0;
  logic               s_axi_awvalid = '0, s_axi_wvalid = '0;
  logic               s_axi_bready = '0, s_axi_arvalid = '0;
  logic               s_axi_rready = '0;
  logic [7:0]         s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0]        s_axi_wdata = '0, s_axi_rdata;
  logic [1:0]         s_axi_bresp, s_axi_rresp;
  logic               s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic               s_axi_arready, s_axi_rvalid, osc_clk_detected;
  logic               ref_valid_selected, free_run, holdover;
  logic               ref_loop_active, osc_loop_active;
  logic signed [23:0] ref_phase_err, osc_phase_err;
  logic [39:0]        analog_sdm_word, osc_fb_sdm_word, ref_fb_sdm_word;
  int                 err_total = 0, checks_done = 0;

  plcm_channel #(.NOM_ANALOG(NA), .NOM_OSC_FB(NO), .NOM_REF_FB(NR)) DUT (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .osc_clk_detected, .ref_valid_selected,
    .ref_phase_err, .osc_phase_err, .analog_sdm_word, .osc_fb_sdm_word,
    .ref_fb_sdm_word, .free_run, .holdover, .ref_loop_active,
    .osc_loop_active);
  plcm_clock_sources SRC (.aclk, .osc_on, .ref_on, .osc_clk_detected,
    .ref_valid_selected, .osc_phase_err, .ref_phase_err);

  initial
  begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end

  task automatic chk(input logic [39:0] got, input logic [39:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      err_total++;
      $display("wrong value at %0t: got %h exp %h", $time, got, exp);
    end
  endtask : chk

  // Unmapped places lie above the last register word
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end
    while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    chk(s_axi_bresp, a > 8'h18 ? 2'h2 : 2'h0);
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end
    while (!s_axi_rvalid);
    d = s_axi_rdata;
    s_axi_rready <= 1'b0;
    chk(s_axi_rresp, a > 8'h18 ? 2'h2 : 2'h0);
  endtask : rd

  // Covers source lag, detector synchronisers and word registers
  task automatic settle;
    repeat (12) @(posedge aclk);
  endtask : settle

  task automatic t_reset;
    logic [31:0] d;
    chk(free_run, 1'b1);
    chk(analog_sdm_word, NA);
    rd(8'h00, d);
    chk(d, plcm_pkg::CTRL_RESET);
    rd(8'h18, d);
    chk(d, NA[39:32]);
    wr(8'h20, 32'h5);
    rd(8'h20, d);
    chk(d, '0);
  endtask : t_reset

  task automatic t_three;
    logic [31:0] d;
    wr(8'h00, 32'h3);
    osc_on <= 1'b1;
    settle();
    chk({osc_loop_active, ref_loop_active}, 2'b10);
    chk(analog_sdm_word != NA, 1'b1);
    ref_on <= 1'b1;
    settle();
    chk(osc_fb_sdm_word != NO, 1'b1);
    rd(8'h10, d);
    chk(d[1:0], plcm_pkg::ST_REF_ACQ);
    ref_on <= 1'b0;
    settle();
    chk({holdover, osc_loop_active}, 2'b11);
    chk(osc_fb_sdm_word, NO);
    ref_on <= 1'b1;
    settle();
    chk({holdover, ref_loop_active}, 2'b01);
    wr(8'h00, 32'h0);
    settle();
    chk(free_run, 1'b1);
  endtask : t_three

  task automatic t_two_ref;
    osc_on <= 1'b0;
    wr(8'h00, 32'h1);
    settle();
    chk(ref_loop_active, 1'b1);
    chk(analog_sdm_word != NA, 1'b1);
    chk(osc_fb_sdm_word, NO);
    ref_on <= 1'b0;
    settle();
    chk(holdover, 1'b1);
    chk(analog_sdm_word, NA);
  endtask : t_two_ref

  task automatic t_two_osc;
    wr(8'h00, 32'h2);
    ref_on <= 1'b1;
    osc_on <= 1'b1;
    settle();
    chk({osc_loop_active, ref_loop_active}, 2'b10);
    chk(analog_sdm_word != NA, 1'b1);
    osc_on <= 1'b0;
    settle();
    chk(free_run, 1'b1);
    chk(analog_sdm_word, NA);
  endtask : t_two_osc

  // Two up, one down, then both bits, which does nothing
  task automatic dco_run(input logic [31:0] ctrl);
    wr(8'h00, 32'h0);
    wr(8'h00, ctrl);
    wr(8'h0C, 32'h1);
    wr(8'h0C, 32'h1);
    wr(8'h0C, 32'h2);
    wr(8'h0C, 32'h3);
    @(posedge aclk);
    if (ctrl[3]) chk(osc_fb_sdm_word, NO + STP);
    else chk(ref_fb_sdm_word, NR + STP);
  endtask : dco_run

  task automatic test_done;
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : test_done

  initial
  begin
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (3) @(posedge aclk);
    t_reset();
    t_three();
    t_two_ref();
    t_two_osc();
    wr(8'h04, STP[31:0]);
    wr(8'h08, {24'h0, STP[39:32]});
    dco_run(32'h7);
    dco_run(32'h5);
    dco_run(32'hA);
    test_done();
  end

  initial
  begin
    repeat (5000) @(posedge aclk);
    err_total++;
    test_done();
  end
endmodule : plcm_channel_tb_top

// file: testbench/plcm_clock_sources.sv
// Behavioural stable-oscillator and reference sources
`timescale 1ns/1ps
module plcm_clock_sources #(
  parameter int unsigned DLY = 3
) (
  // Clock and scenario control
  input  wire logic                         aclk,
  input  wire logic                         osc_on,
  input  wire logic                         ref_on,
  // Detector pins and phase words
  output logic                              osc_clk_detected,
  output logic                              ref_valid_selected,
  output logic signed [plcm_pkg::ERR_W-1:0] osc_phase_err,
  output logic signed [plcm_pkg::ERR_W-1:0] ref_phase_err
);
  logic [DLY-1:0] osc_q = '0;
  logic [DLY-1:0] ref_q = '0;

  // Detection trails the source, as a clock monitor would
  always @(posedge aclk)
  begin
    osc_q <= {osc_q[DLY-2:0], osc_on};
    ref_q <= {ref_q[DLY-2:0], ref_on};
  end
  assign osc_clk_detected   = osc_q[DLY-1];
  assign ref_valid_selected = ref_q[DLY-1];
  // Loop bandwidths stay with software; only a standing error is shown
  assign osc_phase_err = osc_clk_detected ? 24'sh000010 : '0;
  assign ref_phase_err = ref_valid_selected ? 24'sh000010 : '0;
endmodule : plcm_clock_sources
